// ==== dv/cdid_checker.sv ====
// assertions on the instruction decoder's ports
module cdid_checker #(
  parameter CLEAR_CYCLES = 20
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire instr_data_select_in,
  input wire read_write_dir_in,
  input wire [7:0] data_in,
  input wire busy_indicator_out,
  input wire [6:0] position_counter_out,
  input wire [6:0] display_shift_out,
  input wire cursor_dir_out,
  input wire shift_on_access_out,
  input wire display_on_out,
  input wire cursor_on_out,
  input wire blink_on_out,
  input wire glyph_select_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // length of the current busy stretch, clear is the longest
  reg [31:0] busy_run;
  always @(posedge sys_clk_in) begin
    busy_run <= (rst_in || !busy_indicator_out) ? 32'h0 : busy_run + 1;
  end
  sequence instr_taken(int n);
    $rose(busy_indicator_out) && !instr_data_select_in &&
      !read_write_dir_in && (data_in >> n) == 8'h01;
  endsequence
  sequence data_taken;
    $rose(busy_indicator_out) && instr_data_select_in;
  endsequence
  a_clear_zeroes: assert property (instr_taken(0) |->
    position_counter_out == 7'h00 ##1 busy_indicator_out[*8])
    else $error("clear did not zero counter or hold busy");
  a_busy_bounded: assert property (busy_run <= CLEAR_CYCLES)
    else $error("busy held too long");
  a_home_origin: assert property (instr_taken(1) |->
    position_counter_out == 7'h00 && display_shift_out == 7'h00)
    else $error("home did not return to origin");
  a_entry_fields: assert property (instr_taken(2) |->
    cursor_dir_out == data_in[1] && shift_on_access_out == data_in[0])
    else $error("entry mode bits not stored");
  a_display_fields: assert property (instr_taken(3) |->
    {display_on_out, cursor_on_out, blink_on_out} == data_in[2:0])
    else $error("display control bits not stored");
  a_glyph_address: assert property (instr_taken(6) |->
    glyph_select_out && position_counter_out == {1'b0, data_in[5:0]})
    else $error("glyph address not loaded");
  a_text_address: assert property (instr_taken(7) |->
    !glyph_select_out && position_counter_out == data_in[6:0])
    else $error("text address not loaded");
  a_access_step: assert property (data_taken |->
    position_counter_out - $past(position_counter_out) ==
    (cursor_dir_out ? 7'h01 : 7'h7F))
    else $error("counter did not step by one");
  a_no_auto_shift: assert property (data_taken ##0
    !shift_on_access_out |-> $stable(display_shift_out))
    else $error("display shifted with shift flag off");
  a_shift_follows: assert property (data_taken ##0
    shift_on_access_out |->
    display_shift_out - $past(display_shift_out) ==
    (cursor_dir_out ? 7'h01 : 7'h7F))
    else $error("display did not shift with access");
endmodule // cdid_checker

bind char_display_instruction_decoder cdid_checker #(
  .CLEAR_CYCLES(CLEAR_CYCLES)) i_chk (.*);

// ==== dv/cdid_host.sv ====
// host model driving the decoder's bus pins
module cdid_host (
  input wire sys_clk_in,
  output logic strobe_out,
  output logic select_out,
  output logic dir_out,
  output logic [7:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    strobe_out = 1'b0;
    select_out = 1'b0;
    dir_out = 1'b0;
    bus_out = 8'h00;
  end
  // pins held well past the decoder's sampling delay
  task automatic xfer(input logic s, input logic r, input logic [7:0] d);
    if (!s && !r && d[7:1] == 7'h01) d[0] = 1'b0;
    @(negedge sys_clk_in);
    select_out = s;
    dir_out = r;
    bus_out = d;
    strobe_out = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    strobe_out = 1'b0;
    bus_out = ~d; // released bus keeps no value
    repeat (2) @(negedge sys_clk_in);
  endtask
endmodule // cdid_host

// ==== dv/char_display_instruction_decoder_tb.sv ====
// testbench for the character display instruction decoder
`include "char_display_defines.vh"
module char_display_instruction_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLR = 40;
  logic sys_clk_in, rst_in, strobe, sel, dir, busy, oe, cdir, son;
  logic don, con, blk, pwr, bw, lines, font, fhi, flo, glyph, en, gfx;
  logic [7:0] bus, dout;
  logic [6:0] pos, dsh;
  int n_errors = 0;
  int samples_checked = 0;
  cdid_host i_host (.sys_clk_in(sys_clk_in), .strobe_out(strobe),
    .select_out(sel), .dir_out(dir), .bus_out(bus));
  char_display_instruction_decoder #(.CLEAR_CYCLES(CLR)) i_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(en),
    .strobe_in(strobe), .instr_data_select_in(sel),
    .read_write_dir_in(dir), .data_in(bus), .data_out(dout),
    .data_oe_out(oe), .busy_indicator_out(busy),
    .position_counter_out(pos), .display_shift_out(dsh),
    .cursor_dir_out(cdir), .shift_on_access_out(son),
    .display_on_out(don), .cursor_on_out(con), .blink_on_out(blk),
    .graphic_mode_out(gfx), .power_on_out(pwr), .bus_width_select_out(bw),
    .two_lines_out(lines), .font_out(font), .font_table_hi_out(fhi),
    .font_table_lo_out(flo), .glyph_select_out(glyph));
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task conclude;
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task cmd(input logic [7:0] d); i_host.xfer(1'b0, 1'b0, d); endtask
  task wd(input logic [7:0] d); i_host.xfer(1'b1, 1'b0, d); endtask
  task rd; i_host.xfer(1'b1, 1'b1, 8'h00); endtask
  task t_text;
    cmd(8'h90);
    wd(8'hA5);
    wd(8'h3C);
    i_host.xfer(1'b0, 1'b1, 8'h00);
    chk(dout, 8'h12);
    chk({7'h00, oe}, 8'h01);
    cmd(8'h90);
    chk({7'h00, oe}, 8'h00);
    rd;
    chk(dout, 8'hA5);
    rd;
    chk(dout, 8'h3C);
  endtask
  task t_entry;
    cmd(8'h04);
    chk({6'h00, cdir, son}, 8'h00);
    cmd(8'h90);
    wd(8'h11);
    chk({dsh, 1'b0}, 8'h00);
    chk({1'b0, pos}, 8'h0F);
    cmd(8'h07);
    wd(8'h22);
    rd;
    chk(dout, 8'h11);
    chk({1'b0, dsh}, 8'h02);
    cmd(8'h06);
  endtask
  task t_glyph;
    cmd(8'h45);
    chk({glyph, pos}, 8'h85);
    wd(8'h1F);
    cmd(8'h85);
    wd(8'h77);
    cmd(8'h45);
    rd;
    chk(dout, 8'h1F);
    cmd(8'h85);
    chk({glyph, pos}, 8'h05);
    cmd(8'h14);
    chk({1'b0, pos}, 8'h06);
    cmd(8'h10);
    rd;
    chk(dout, 8'h77);
  endtask
  task t_disp;
    cmd(8'h0D);
    chk({5'h0, don, con, blk}, 8'h05);
    cmd(8'h0A);
    chk({5'h0, don, con, blk}, 8'h02);
    en = 1'b0;
    cmd(8'h0F); // frozen clock enable, strobe must be missed
    en = 1'b1;
    chk({5'h0, don, con, blk}, 8'h02);
  endtask
  task t_clear;
    int n;
    cmd(8'h85);
    cmd(8'h01);
    chk({7'h0, busy}, 8'h01);
    cmd(8'h93); // lands while busy, must be dropped
    i_host.xfer(1'b0, 1'b1, 8'h00);
    chk(dout, 8'h80);
    for (n = 0; busy && n < 2 * CLR; n++) @(negedge sys_clk_in);
    if (busy) begin
      n_errors++;
      $display("unexpected at %0t: busy stuck after clear", $time);
      conclude;
    end
    chk({1'b0, pos}, 8'h00);
    cmd(8'h85);
    rd;
    chk(dout, `BLANK_CHAR);
    cmd(8'h02);
    chk({1'b0, pos}, 8'h00);
  endtask
  task t_func;
    cmd(8'h3B);
    chk({bw, lines, font, fhi, flo, pwr, 2'b00}, 8'hDC);
    cmd(8'h18);
    chk({6'h00, gfx, pwr}, 8'h02);
    cmd(8'hB5);
    cmd(8'h2C);
    chk({bw, lines, font, fhi, flo, pwr, 2'b00}, 8'h64);
    i_host.xfer(1'b0, 1'b1, 8'h00);
    chk({dout[7:4], 4'h0}, 8'h30);
    i_host.xfer(1'b0, 1'b1, 8'h00);
    chk({dout[7:4], 4'h0}, 8'h50);
    cmd(8'h30);
    cmd(8'h00);
    chk({7'h0, bw}, 8'h01);
  endtask
  initial begin
    rst_in = 1'b1;
    en = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    rst_in = 1'b0;
    chk({busy, cdir, bw, glyph, 4'h0}, 8'h60);
    t_text;
    t_entry;
    t_glyph;
    t_disp;
    t_clear;
    t_func;
    conclude;
  end
endmodule // char_display_instruction_decoder_tb

// ==== src/char_display_defines.vh ====
// constants for the character display instruction decoder
`ifndef CHAR_DISPLAY_DEFINES_VH
`define CHAR_DISPLAY_DEFINES_VH
`define CLK_HZ 40000000
`define CLEAR_TIME_US 6200
`define CLEAR_CYCLES ((`CLEAR_TIME_US * (`CLK_HZ / 1000000)))
`define TEXT_DEPTH 128
`define GLYPH_DEPTH 64
`define BIT_CLEAR 0
`define BIT_HOME 1
`define BIT_ENTRY 2
`define BIT_DISPLAY 3
`define BIT_SHIFT 4
`define BIT_FUNC 5
`define BIT_GLYPH 6
`define BIT_TEXT 7
`define BLANK_CHAR 8'h20
`define ZERO_ADDR 7'h00
`endif

// ==== src/char_display_instruction_decoder.v ====
// instruction decoder for a character display controller
// Functional notes
// - clear code blanks all text memory and zeroes position counter.
// - home code zeroes position counter and undoes display shift.
// - entry mode stores cursor direction and shift-on-access flag.
// - display control stores display on, cursor visible, blink.
// - shift code latches graphic mode from bit three; bit three clear moves cursor, set loads power from bit two; memory untouched.
// - function set latches width, lines, font, font table.
// - function set also always switches the internal power state on.
// - glyph address set loads six bits, selects glyph memory.
// - text address set loads seven bits, selects text memory.
// - status read returns busy on bit seven, counter below.
// - data write stores byte in the selected memory.
// - data read returns byte at current selected address.
// - while busy only status read is accepted.
// - each data access steps the position counter by one.
// - shift flag zero means no display shift on access.
`include "char_display_defines.vh"
module char_display_instruction_decoder #(
  parameter CLEAR_CYCLES = `CLEAR_CYCLES
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  input wire strobe_in,
  input wire instr_data_select_in,
  input wire read_write_dir_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_out,
  output reg busy_indicator_out,
  output reg [6:0] position_counter_out,
  output reg [6:0] display_shift_out,
  output reg cursor_dir_out,
  output reg shift_on_access_out,
  output reg display_on_out,
  output reg cursor_on_out,
  output reg blink_on_out,
  output reg graphic_mode_out,
  output reg power_on_out,
  output reg bus_width_select_out,
  output reg two_lines_out,
  output reg font_out,
  output reg font_table_hi_out,
  output reg font_table_lo_out,
  output reg glyph_select_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CLEAR = 3'b010;
  localparam ST_BUSY = 3'b100;
  reg [7:0] text_memory [0:`TEXT_DEPTH-1];
  reg [7:0] user_glyph_memory [0:`GLYPH_DEPTH-1];
  reg strobe_s1, strobe_s2, strobe_s3;
  reg rs_s1, rs_s2, rw_s1, rw_s2;
  reg [7:0] db_s1, db_s2;
  reg [2:0] state;
  reg [23:0] wait_count;
  reg nib_phase;
  reg [3:0] nib_hold;
  reg rd_second;
  reg [7:0] rd_byte;
  reg [7:0] cmd;
  reg [7:0] byte_val;
  reg byte_done;
  wire strobe_rise = strobe_s2 & ~strobe_s3;
  wire [6:0] step_addr = cursor_dir_out ? position_counter_out + 7'd1 :
    position_counter_out - 7'd1;
  wire [6:0] step_shift = cursor_dir_out ? display_shift_out + 7'd1 :
    display_shift_out - 7'd1;
  // clear count cut to the counter's width on purpose
  wire [31:0] clear_load = CLEAR_CYCLES - 1;
  wire [7:0] sel_byte = glyph_select_out ?
    user_glyph_memory[position_counter_out[5:0]] :
    text_memory[position_counter_out];
  wire [7:0] status_byte = {busy_indicator_out, position_counter_out};
  // narrow bus assembles a byte from two strobes on bits seven to four
  always @* begin
    byte_val = bus_width_select_out ? db_s2 : {nib_hold, db_s2[7:4]};
    byte_done = bus_width_select_out | nib_phase;
  end
  genvar gi;
  generate
    for (gi = 0; gi < `TEXT_DEPTH; gi = gi + 1) begin : g_text
      always @(posedge sys_clk_in) begin
        if (clk_en_in) begin
          if (state == ST_CLEAR) begin
            text_memory[gi] <= `BLANK_CHAR;
          end else if (state == ST_IDLE && strobe_rise && byte_done &&
              rs_s2 && !rw_s2 && !glyph_select_out &&
              position_counter_out == gi) begin
            text_memory[gi] <= byte_val;
          end
        end
      end
    end
  endgenerate
  always @(posedge sys_clk_in) begin
    if (clk_en_in && state == ST_IDLE && strobe_rise && byte_done &&
        rs_s2 && !rw_s2 && glyph_select_out) begin
      user_glyph_memory[position_counter_out[5:0]] <= byte_val;
    end
  end
  // pins come from the host's domain, so two flops before any use
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      rs_s1 <= 1'b0;
      rs_s2 <= 1'b0;
      rw_s1 <= 1'b0;
      rw_s2 <= 1'b0;
      db_s1 <= 8'h00;
      db_s2 <= 8'h00;
    end else if (clk_en_in) begin
      strobe_s1 <= strobe_in;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      rs_s1 <= instr_data_select_in;
      rs_s2 <= rs_s1;
      rw_s1 <= read_write_dir_in;
      rw_s2 <= rw_s1;
      db_s1 <= data_in;
      db_s2 <= db_s1;
    end
  end
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
      busy_indicator_out <= 1'b0;
      position_counter_out <= `ZERO_ADDR;
      display_shift_out <= 7'h00;
      cursor_dir_out <= 1'b1;
      shift_on_access_out <= 1'b0;
      display_on_out <= 1'b0;
      cursor_on_out <= 1'b0;
      blink_on_out <= 1'b0;
      graphic_mode_out <= 1'b0;
      power_on_out <= 1'b0;
      bus_width_select_out <= 1'b1;
      two_lines_out <= 1'b0;
      font_out <= 1'b0;
      font_table_hi_out <= 1'b0;
      font_table_lo_out <= 1'b0;
      glyph_select_out <= 1'b0;
      state <= ST_IDLE;
      wait_count <= 24'h000000;
      nib_phase <= 1'b0;
      nib_hold <= 4'h0;
      rd_second <= 1'b0;
      rd_byte <= 8'h00;
      cmd <= 8'h00;
    end else if (clk_en_in) begin
      case (state)
        ST_CLEAR: begin
          if (wait_count == 24'h000000) begin
            state <= ST_IDLE;
            busy_indicator_out <= 1'b0;
          end else begin
            wait_count <= wait_count - 24'h000001;
          end
        end
        ST_BUSY: begin
          state <= ST_IDLE;
          busy_indicator_out <= 1'b0;
        end
        ST_IDLE: begin
          if (strobe_rise && rw_s2) begin
            // reads: second half of a narrow read returns stored low nibble
            data_oe_out <= 1'b1;
            if (!bus_width_select_out && rd_second) begin
              data_out <= {rd_byte[3:0], 4'h0};
              rd_second <= 1'b0;
            end else begin
              rd_byte <= rs_s2 ? sel_byte : status_byte;
              data_out <= rs_s2 ? sel_byte : status_byte;
              rd_second <= ~bus_width_select_out;
              if (rs_s2) begin
                position_counter_out <= step_addr;
                if (shift_on_access_out) begin
                  display_shift_out <= step_shift;
                end
                busy_indicator_out <= 1'b1;
                state <= ST_BUSY;
              end
            end
          end else if (strobe_rise && !rw_s2) begin
            data_oe_out <= 1'b0;
            nib_hold <= db_s2[7:4];
            nib_phase <= ~bus_width_select_out & ~nib_phase;
            if (byte_done && rs_s2) begin
              position_counter_out <= step_addr;
              if (shift_on_access_out) begin
                display_shift_out <= step_shift;
              end
              busy_indicator_out <= 1'b1;
              state <= ST_BUSY;
            end else if (byte_done) begin
              busy_indicator_out <= 1'b1;
              state <= ST_BUSY;
              cmd <= byte_val;
              if (byte_val[`BIT_TEXT]) begin
                position_counter_out <= byte_val[6:0];
                glyph_select_out <= 1'b0;
              end else if (byte_val[`BIT_GLYPH]) begin
                position_counter_out <= {1'b0, byte_val[5:0]};
                glyph_select_out <= 1'b1;
              end else if (byte_val[`BIT_FUNC]) begin
                bus_width_select_out <= byte_val[4];
                two_lines_out <= byte_val[3];
                font_out <= byte_val[2];
                font_table_hi_out <= byte_val[1];
                font_table_lo_out <= byte_val[0];
                power_on_out <= 1'b1;
              end else if (byte_val[`BIT_SHIFT]) begin
                graphic_mode_out <= byte_val[3];
                if (!byte_val[3]) begin
                  // cursor moves only; right steps up
                  position_counter_out <= byte_val[2] ?
                    position_counter_out + 7'd1 :
                    position_counter_out - 7'd1;
                end else begin
                  power_on_out <= byte_val[2];
                end
              end else if (byte_val[`BIT_DISPLAY]) begin
                display_on_out <= byte_val[2];
                cursor_on_out <= byte_val[1];
                blink_on_out <= byte_val[0];
              end else if (byte_val[`BIT_ENTRY]) begin
                cursor_dir_out <= byte_val[1];
                shift_on_access_out <= byte_val[0];
              end else if (byte_val[`BIT_HOME]) begin
                position_counter_out <= `ZERO_ADDR;
                display_shift_out <= 7'h00;
                glyph_select_out <= 1'b0;
              end else if (byte_val[`BIT_CLEAR]) begin
                position_counter_out <= `ZERO_ADDR;
                display_shift_out <= 7'h00;
                glyph_select_out <= 1'b0;
                wait_count <= clear_load[23:0];
                state <= ST_CLEAR;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          busy_indicator_out <= 1'b0;
        end
      endcase
      // only status reads get through while busy, others are lost;
      // narrow mode gets the whole status byte on every strobe here
      if (state != ST_IDLE && strobe_rise && rw_s2 && !rs_s2) begin
        data_oe_out <= 1'b1;
        data_out <= status_byte;
      end
    end
  end
endmodule // char_display_instruction_decoder
